/* File: shared/touch_ctl_pkg.sv */
// shared constants and types for the touch converter control and status block
`default_nettype none
package touch_ctl_pkg;
  // ==========================================================
  // clock and settling times
  localparam int CLK_NS = 4;
  localparam int T_100US_NS = 100000;
  localparam int T_500US_NS = 500000;
  localparam int T_1MS_NS = 1000000;
  localparam int T_5MS_NS = 5000000;
  localparam int T_10MS_NS = 10000000;
  localparam int T_50MS_NS = 50000000;
  localparam int TCNT_W = 24;
  localparam logic [23:0] TCNT_LAST = 24'h000001;
  localparam logic [23:0] TCNT_ZERO = 24'h000000;
  // ==========================================================
  // register map (6-bit address)
  localparam int ADDR_MSB = 5;
  localparam logic [5:0] ADDR_CTL = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h01;
  localparam logic [5:0] ADDR_X = 6'h10;
  localparam logic [5:0] ADDR_Y = 6'h11;
  localparam logic [5:0] ADDR_Z1 = 6'h12;
  localparam int IX_CTL = 0;
  localparam int IX_STATUS = 1;
  localparam int IX_DATA = 2;
  localparam int NREG = 5;
  localparam int NDATA = 3;
  localparam int WORD_MSB = 15;
  localparam logic [15:0] RD_NONE = 16'h0000;
  // ==========================================================
  // field positions and reset values
  localparam int CTL_SCAN_LSB = 10;
  localparam int CTL_AVG_LSB = 6;
  localparam int CTL_SETTLE_LSB = 1;
  localparam int CTL_FILT_BIT = 0;
  localparam int ST_FN_LSB = 14;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [1:0] FN_RST = 2'h2;
  localparam logic [1:0] FN_PEN = 2'h0;
  localparam logic [1:0] FN_READY = 2'h1;
  localparam logic [7:0] STATUS_PAD = 8'h00;
  localparam logic [3:0] SCAN_XY = 4'h1;
  localparam logic [3:0] SCAN_XYZ = 4'h2;
  localparam logic [2:0] SETTLE_MAX = 3'h7;
  // averaging sample counts, four 5-bit entries indexed by the count field
  localparam logic [19:0] AVG_MEAN_TBL = {5'h10, 5'h08, 5'h04, 5'h00};
  localparam logic [19:0] AVG_MEDIAN_TBL = {5'h0F, 5'h09, 5'h05, 5'h00};
  // ==========================================================
  // serial frame and synchroniser layout
  localparam logic [5:0] CNT_CMD_LAST = 6'h0F;
  localparam logic [5:0] CNT_LAST = 6'h1F;
  localparam logic [5:0] CNT_END = 6'h20;
  localparam int CMD_RD_BIT = 15;
  localparam int SY_WR = 0;
  localparam int SY_RD = 1;
  localparam int SY_CS = 2;
  localparam int SY_PEN = 3;
  localparam int NSYNC = 4;
  localparam logic [3:0] SYNC_RST = 4'hC;
  // ==========================================================
  // types
  typedef enum logic [1:0] {TMR_IDLE = 2'b01, TMR_COUNT = 2'b10} settle_e;
  typedef struct packed {
    logic set_done;
    logic [2:0] store;
    logic [15:0] result;
  } conv_evt_s;
  typedef struct packed {
    logic [3:0] scan_mode;
    logic scan_run;
    logic [4:0] avg_samples;
    logic filter_median;
  } conv_cfg_s;
endpackage : touch_ctl_pkg
`default_nettype wire

/* File: rtl/touch_adc_control_status.sv */
// touch converter control, status flags, pen/ready pin and serial register port
`default_nettype none
// Behaviour
// - after drivers enable, wait selected settle time (0..50 ms) before sampling.
// - filter select bit D0: 0 mean, 1 median; resets to mean.
// - pin function 00: pin low while pen is touching.
// - pin function 01: pin low once a conversion set completes.
// - pin function 01 while scanning: low while any result stays unread.
// - pin function 1x: low on pen touch, high when conversions finish.
// - status D13 reads 1 when converter is powered down.
// - status D12 reads 1 when device controls conversions itself.
// - status D11 sets on set done, clears after all results read.
// - X flag D10 sets on new X result, clears after X read.
// - Y flag D9 sets on new Y result, clears after Y read.
// - Z1 flag D8 sets on new Z1 result, clears after Z1 read.
// - average count gives 0/4/8/16 mean or 0/5/9/15 median samples.
// - scan codes 0001 and 0010 run until pen lifts or host stops.
module touch_adc_control_status #(
  parameter int unsigned SETTLE_100US_CYC = touch_ctl_pkg::T_100US_NS / touch_ctl_pkg::CLK_NS,
  parameter int unsigned SETTLE_500US_CYC = touch_ctl_pkg::T_500US_NS / touch_ctl_pkg::CLK_NS,
  parameter int unsigned SETTLE_1MS_CYC = touch_ctl_pkg::T_1MS_NS / touch_ctl_pkg::CLK_NS,
  parameter int unsigned SETTLE_5MS_CYC = touch_ctl_pkg::T_5MS_NS / touch_ctl_pkg::CLK_NS,
  parameter int unsigned SETTLE_10MS_CYC = touch_ctl_pkg::T_10MS_NS / touch_ctl_pkg::CLK_NS,
  parameter int unsigned SETTLE_50MS_CYC = touch_ctl_pkg::T_50MS_NS / touch_ctl_pkg::CLK_NS
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic pen_touch_n,
  input wire touch_ctl_pkg::conv_evt_s conv,
  input wire logic conv_off,
  input wire logic self_ctl,
  input wire logic drivers_on,
  output logic sample_go,
  output touch_ctl_pkg::conv_cfg_s cfg,
  output logic pen_or_ready_pin_n
);
  // ==========================================================
  // serial link side (spi_clk domain)
  logic [5:0] bit_cnt_r;
  logic [15:0] sh_r;
  logic [15:0] cmd_r;
  logic [15:0] tx_r;
  logic [15:0] wr_data_r;
  logic miso_r;
  logic rd_tgl_r;
  logic wr_tgl_r;
  logic [15:0] shadow_r [touch_ctl_pkg::NREG];
  wire [15:0] word_in_w = {sh_r[14:0], spi_mosi};
  wire [5:0] addr_now_w = word_in_w[touch_ctl_pkg::ADDR_MSB:0];
  wire [5:0] cmd_addr_w = cmd_r[touch_ctl_pkg::ADDR_MSB:0];
  wire [15:0] rd_word_w;

  // read mux over the frozen shadow copies; unmapped reads return zero
  assign rd_word_w =
    (addr_now_w == touch_ctl_pkg::ADDR_CTL) ? shadow_r[touch_ctl_pkg::IX_CTL] :
    (addr_now_w == touch_ctl_pkg::ADDR_STATUS) ? shadow_r[touch_ctl_pkg::IX_STATUS] :
    (addr_now_w == touch_ctl_pkg::ADDR_X) ? shadow_r[touch_ctl_pkg::IX_DATA] :
    (addr_now_w == touch_ctl_pkg::ADDR_Y) ? shadow_r[touch_ctl_pkg::IX_DATA + 1] :
    (addr_now_w == touch_ctl_pkg::ADDR_Z1) ? shadow_r[touch_ctl_pkg::IX_DATA + 2] :
    touch_ctl_pkg::RD_NONE;

  // bit counter: chip select high clears it, so the clock may stop between frames
  always_ff @(posedge spi_clk or posedge rst or posedge spi_cs_n)
  begin
    if (rst || spi_cs_n)
      bit_cnt_r <= 6'h00;
    else if (bit_cnt_r != touch_ctl_pkg::CNT_END)
      bit_cnt_r <= bit_cnt_r + 6'h01;
  end

  // shifting, command capture, read data out, events raised on the last edge
  always_ff @(posedge spi_clk or posedge rst)
  begin
    if (rst)
    begin
      sh_r <= 16'h0000;
      cmd_r <= 16'h0000;
      tx_r <= 16'h0000;
      wr_data_r <= 16'h0000;
      miso_r <= 1'h0;
      rd_tgl_r <= 1'h0;
      wr_tgl_r <= 1'h0;
    end
    else
    begin
      sh_r <= word_in_w;
      miso_r <= tx_r[touch_ctl_pkg::WORD_MSB];
      tx_r <= {tx_r[14:0], 1'h0};
      if (bit_cnt_r == touch_ctl_pkg::CNT_CMD_LAST)
      begin
        cmd_r <= word_in_w;
        miso_r <= rd_word_w[touch_ctl_pkg::WORD_MSB];
        tx_r <= {rd_word_w[14:0], 1'h0};
      end
      // final bit of a read marks the word as fully read out
      if (bit_cnt_r == touch_ctl_pkg::CNT_LAST)
      begin
        if (cmd_r[touch_ctl_pkg::CMD_RD_BIT])
          rd_tgl_r <= ~rd_tgl_r;
        else
        begin
          wr_data_r <= word_in_w;
          wr_tgl_r <= ~wr_tgl_r;
        end
      end
    end
  end
  assign spi_miso = miso_r;

  // ==========================================================
  // synchronisers: three stages, a change counts once stages 2 and 3 agree
  wire [3:0] raw_w = {pen_touch_n, spi_cs_n, rd_tgl_r, wr_tgl_r};
  wire [3:0] chg_w;
  wire [3:0] st_w;
  generate
    for (genvar i = 0; i < touch_ctl_pkg::NSYNC; i++)
    begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic st_r;
      assign chg_w[i] = (s2_r == s3_r) && (s3_r != st_r);
      assign st_w[i] = st_r;
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          s1_r <= touch_ctl_pkg::SYNC_RST[i];
          s2_r <= touch_ctl_pkg::SYNC_RST[i];
          s3_r <= touch_ctl_pkg::SYNC_RST[i];
          st_r <= touch_ctl_pkg::SYNC_RST[i];
        end
        else if (ce)
        begin
          s1_r <= raw_w[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (chg_w[i])
            st_r <= s3_r;
        end
      end
    end
  endgenerate

  wire wr_evt = chg_w[touch_ctl_pkg::SY_WR];
  wire rd_evt = chg_w[touch_ctl_pkg::SY_RD];
  wire cs_idle = st_w[touch_ctl_pkg::SY_CS];
  wire pen_down = ~st_w[touch_ctl_pkg::SY_PEN];
  wire pen_press = chg_w[touch_ctl_pkg::SY_PEN] & st_w[touch_ctl_pkg::SY_PEN];
  wire pen_lift = chg_w[touch_ctl_pkg::SY_PEN] & ~st_w[touch_ctl_pkg::SY_PEN];

  // ==========================================================
  // control and status registers (sys_clk domain)
  logic [15:0] ctl_r;
  logic [1:0] pin_fn_r;
  logic ready_r;
  logic pen_evt_r;
  logic pin_n_r;
  touch_ctl_pkg::conv_cfg_s cfg_r;
  logic [2:0] flag_r;
  wire [2:0] flag_nxt;
  wire [2:0] rd_hit;
  wire [15:0] data_w [touch_ctl_pkg::NDATA];

  wire wr_ctl = wr_evt && (cmd_addr_w == touch_ctl_pkg::ADDR_CTL);
  wire wr_st = wr_evt && (cmd_addr_w == touch_ctl_pkg::ADDR_STATUS);
  wire [15:0] ctl_nxt = wr_ctl ? wr_data_r : ctl_r;
  wire [3:0] scan_w = ctl_nxt[touch_ctl_pkg::CTL_SCAN_LSB +: 4];
  wire [1:0] avg_w = ctl_nxt[touch_ctl_pkg::CTL_AVG_LSB +: 2];
  wire median_w = ctl_nxt[touch_ctl_pkg::CTL_FILT_BIT];
  wire [2:0] settle_code_w = ctl_r[touch_ctl_pkg::CTL_SETTLE_LSB +: 3];

  // per-result new-data flags; a store in the clearing cycle wins
  generate
    for (genvar i = 0; i < touch_ctl_pkg::NDATA; i++)
    begin : g_flag
      logic [15:0] data_r;
      assign rd_hit[i] = rd_evt && (cmd_addr_w == 6'(touch_ctl_pkg::ADDR_X + i));
      assign flag_nxt[i] = conv.store[i] | (flag_r[i] & ~rd_hit[i]);
      assign data_w[i] = data_r;
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          flag_r[i] <= 1'h0;
          data_r <= 16'h0000;
        end
        else if (ce)
        begin
          flag_r[i] <= flag_nxt[i];
          if (conv.store[i])
            data_r <= conv.result;
        end
      end
    end
  endgenerate

  // results ready stays up until every flagged result has been read
  wire ready_nxt = conv.set_done | (ready_r & ~((|rd_hit) & ~(|flag_nxt)));
  // pen event for the combined pin function: touch sets, finished set clears
  wire pen_evt_nxt = pen_press | (pen_evt_r & ~conv.set_done);
  // scan run: started by a continuous scan code, ended by any other control write or a lift
  wire scan_run_nxt = wr_ctl ? (scan_w == touch_ctl_pkg::SCAN_XY
                                || scan_w == touch_ctl_pkg::SCAN_XYZ)
                             : (cfg_r.scan_run & ~pen_lift);
  wire [4:0] avg_cnt_w = median_w ? touch_ctl_pkg::AVG_MEDIAN_TBL[avg_w * 5 +: 5]
                                  : touch_ctl_pkg::AVG_MEAN_TBL[avg_w * 5 +: 5];
  wire pin_n_nxt = (pin_fn_r == touch_ctl_pkg::FN_PEN) ? ~pen_down :
                   (pin_fn_r == touch_ctl_pkg::FN_READY) ? ~ready_r :
                   ~pen_evt_r;
  wire [15:0] status_w = {pin_fn_r, conv_off, self_ctl, ready_r,
                          flag_r[0], flag_r[1], flag_r[2],
                          touch_ctl_pkg::STATUS_PAD};

  // register state, all frozen while ce is low
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_r <= touch_ctl_pkg::CTL_RST;
      pin_fn_r <= touch_ctl_pkg::FN_RST;
      ready_r <= 1'h0;
      pen_evt_r <= 1'h0;
      pin_n_r <= 1'h1;
      cfg_r <= '0;
    end
    else if (ce)
    begin
      ctl_r <= ctl_nxt;
      if (wr_st)
        pin_fn_r <= wr_data_r[touch_ctl_pkg::ST_FN_LSB +: 2];
      ready_r <= ready_nxt;
      pen_evt_r <= pen_evt_nxt;
      pin_n_r <= pin_n_nxt;
      cfg_r.scan_mode <= scan_w;
      cfg_r.scan_run <= scan_run_nxt;
      cfg_r.avg_samples <= avg_cnt_w;
      cfg_r.filter_median <= median_w;
    end
  end
  assign cfg = cfg_r;
  assign pen_or_ready_pin_n = pin_n_r;

  // shadows only follow while no frame is open, so the link reads stable words
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      shadow_r <= '{default: 16'h0000};
    else if (ce && cs_idle)
    begin
      shadow_r[touch_ctl_pkg::IX_CTL] <= ctl_r;
      shadow_r[touch_ctl_pkg::IX_STATUS] <= status_w;
      shadow_r[touch_ctl_pkg::IX_DATA] <= data_w[0];
      shadow_r[touch_ctl_pkg::IX_DATA + 1] <= data_w[1];
      shadow_r[touch_ctl_pkg::IX_DATA + 2] <= data_w[2];
    end
  end

  // ==========================================================
  // panel settling timer
  function automatic logic [23:0] settle_len(input logic [2:0] code);
    case (code)
      3'h0: settle_len = touch_ctl_pkg::TCNT_ZERO;
      3'h1: settle_len = 24'(SETTLE_100US_CYC);
      3'h2: settle_len = 24'(SETTLE_500US_CYC);
      3'h3: settle_len = 24'(SETTLE_1MS_CYC);
      3'h4: settle_len = 24'(SETTLE_5MS_CYC);
      3'h5: settle_len = 24'(SETTLE_10MS_CYC);
      default: settle_len = 24'(SETTLE_50MS_CYC);
    endcase
  endfunction : settle_len

  touch_ctl_pkg::settle_e tmr_r;
  logic [23:0] tcnt_r;
  logic go_r;
  wire [23:0] settle_w = settle_len(settle_code_w);

  // timer: no sampling until the chosen settle count has run out
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tmr_r <= touch_ctl_pkg::TMR_IDLE;
      tcnt_r <= touch_ctl_pkg::TCNT_ZERO;
      go_r <= 1'h0;
    end
    else if (ce)
    begin
      go_r <= 1'h0;
      case (tmr_r)
        touch_ctl_pkg::TMR_IDLE:
          if (drivers_on)
          begin
            if (settle_w == touch_ctl_pkg::TCNT_ZERO)
              go_r <= 1'h1;
            else
            begin
              tcnt_r <= settle_w;
              tmr_r <= touch_ctl_pkg::TMR_COUNT;
            end
          end
        touch_ctl_pkg::TMR_COUNT:
          if (tcnt_r == touch_ctl_pkg::TCNT_LAST)
          begin
            go_r <= 1'h1;
            tmr_r <= touch_ctl_pkg::TMR_IDLE;
          end
          else
            tcnt_r <= tcnt_r - touch_ctl_pkg::TCNT_LAST;
        default:
          tmr_r <= touch_ctl_pkg::TMR_IDLE;
      endcase
    end
  end
  assign sample_go = go_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  chk_pen_only: assert property (
    ce && pin_fn_r == touch_ctl_pkg::FN_PEN |=> pin_n_r == !$past(pen_down))
    else $error("pen-only pin does not follow pen");
  chk_ready_only: assert property (
    ce && pin_fn_r == touch_ctl_pkg::FN_READY |=> pin_n_r == !$past(ready_r))
    else $error("ready-only pin does not follow ready flag");
  chk_pin_both: assert property (
    ce && conv.set_done && pin_fn_r[1] ##1 ce |=> pin_n_r)
    else $error("combined pin not released after set done");
  chk_x_set: assert property (
    ce && conv.store[0] |=> flag_r[0] && data_w[0] == $past(conv.result))
    else $error("x flag or data not stored");
  chk_x_hold: assert property (
    ce && flag_r[0] && !rd_hit[0] |=> flag_r[0])
    else $error("x flag cleared without full read");
  chk_ready_set: assert property (
    ce && conv.set_done |=> ready_r)
    else $error("ready flag not set by finished set");
  chk_settle_zero: assert property (
    ce && tmr_r == touch_ctl_pkg::TMR_IDLE && drivers_on
    && settle_code_w == 3'h0 |=> go_r)
    else $error("zero settle did not start sampling");
  chk_settle_max: assert property (
    ce && tmr_r == touch_ctl_pkg::TMR_IDLE && drivers_on
    && settle_code_w == touch_ctl_pkg::SETTLE_MAX |=> tcnt_r == 24'(SETTLE_50MS_CYC) && !go_r)
    else $error("code 111 not longest settle");
  chk_scan_lift: assert property (
    ce && pen_lift && !wr_ctl |=> !cfg_r.scan_run)
    else $error("scan kept running after pen lift");
endmodule : touch_adc_control_status
`default_nettype wire

/* File: test/spi_host_model.sv */
// host-side serial master model that frames register accesses
`default_nettype none
module spi_host_model #(
  parameter int HALF_NS = 24
)(
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // idle levels: clock stands still and select is high between frames
  initial
  begin
    spi_clk = 1'h0;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
  end
  // ==========================================================
  // one frame, command then data, msb first; nbits under 32 aborts it
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] wdata, input int nbits,
    output logic [15:0] rdata);
    logic [31:0] frame;
    frame = {cmd, wdata};
    rdata = 16'h0000;
    #7; // odd lead-in keeps the link phase drifting against the system clock
    spi_cs_n = 1'h0;
    #HALF_NS;
    for (int i = 0; i < nbits; i++)
    begin
      spi_mosi = frame[31 - i];
      #HALF_NS spi_clk = 1'h1;
      #HALF_NS spi_clk = 1'h0;
      if (i >= 15 && i <= 30)
      begin
        rdata[30 - i] = spi_miso; // read word is sampled on falling edges
      end
    end
    #HALF_NS spi_cs_n = 1'h1;
    spi_mosi = ~spi_mosi; // a released line must not keep showing its last bit
    #(4 * HALF_NS);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: test/touch_adc_control_status_tb_top.sv */
// self-checking bench for the touch converter control and status block
`default_nettype none
module touch_adc_control_status_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, ce, spi_clk, spi_cs_n, spi_mosi, spi_miso, pen_touch_n;
  logic conv_off, self_ctl, drivers_on, sample_go, pin_n;
  touch_ctl_pkg::conv_evt_s conv;
  touch_ctl_pkg::conv_cfg_s cfg;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [15:0] rd;
  logic [4:0] avg_exp [8] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h00, 5'h05, 5'h09, 5'h0F};
  // code 1 keeps its true 100 us count, so one settle length is checked at full size
  int settle_exp [8] = '{1, touch_ctl_pkg::T_100US_NS / touch_ctl_pkg::CLK_NS + 1,
    4, 5, 6, 7, 9, 9};
  // ==========================================================
  // clock, design with shortened settle counts above 100 us, host model
  initial
  begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  touch_adc_control_status #(.SETTLE_500US_CYC(3), .SETTLE_1MS_CYC(4),
    .SETTLE_5MS_CYC(5), .SETTLE_10MS_CYC(6), .SETTLE_50MS_CYC(8)) u_dut (.sys_clk(sys_clk),
    .rst(rst), .ce(ce), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .pen_touch_n(pen_touch_n), .conv(conv), .conv_off(conv_off),
    .self_ctl(self_ctl), .drivers_on(drivers_on), .sample_go(sample_go), .cfg(cfg),
    .pen_or_ready_pin_n(pin_n));
  spi_host_model u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));
  // ==========================================================
  // compare, access and stimulus tasks
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] unused;
    u_host.xfer({10'h000, a}, d, 32, unused);
    @(negedge sys_clk); // realign so later checks never sit on a sampling edge
  endtask : wr
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] got;
    u_host.xfer({1'h1, 9'h000, a}, 16'h0000, 32, got);
    @(negedge sys_clk);
    chk_word(what, exp, got);
  endtask : rd_chk
  task automatic evt(input logic [2:0] st, input logic done, input logic [15:0] res);
    @(negedge sys_clk);
    conv.store = st;
    conv.set_done = done;
    conv.result = res;
    @(negedge sys_clk);
    conv = '0;
  endtask : evt
  task automatic pen(input logic v);
    @(negedge sys_clk);
    pen_touch_n = v;
    repeat (8) @(negedge sys_clk); // pen passes three sync stages and two registers
  endtask : pen
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // ==========================================================
  // hang guard: well above the roughly 48000 cycles the tests need, full 100 us settle included
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      n_errors++;
      final_report();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'h1;
    ce = 1'h1;
    pen_touch_n = 1'h1;
    conv = '0;
    conv_off = 1'h0;
    self_ctl = 1'h0;
    drivers_on = 1'h0;
    repeat (5) @(negedge sys_clk);
    rst = 1'h0;
    repeat (4) @(negedge sys_clk);
    chk_bit("pin_idle", 1'h1, pin_n);
    chk_word("cfg_rst", 16'h0000, {5'h00, cfg});
    rd_chk("ctl_rst", touch_ctl_pkg::ADDR_CTL, 16'h0000);
    rd_chk("status_rst", touch_ctl_pkg::ADDR_STATUS, 16'h8000);
    rd_chk("unmapped", 6'h05, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 8; k++)
    begin
      wr(touch_ctl_pkg::ADDR_CTL, {6'h00, 2'h3, k[1:0], 2'h2, 3'h0, k[2]});
      chk_word("avg", {11'h000, avg_exp[k]}, {11'h000, cfg.avg_samples});
      chk_bit("filter", k[2], cfg.filter_median);
      rd_chk("ctl_rd", touch_ctl_pkg::ADDR_CTL, {6'h00, 2'h3, k[1:0], 2'h2, 3'h0, k[2]});
    end
    $display("test averaging done");
    for (int c = 0; c < 8; c++)
    begin
      wr(touch_ctl_pkg::ADDR_CTL, {12'h000, c[2:0], 1'h0});
      drivers_on = 1'h1;
      @(negedge sys_clk);
      drivers_on = 1'h0;
      n = 1;
      while (sample_go !== 1'h1 && n < 30000)
      begin
        @(negedge sys_clk);
        n++;
      end
      chk_word("settle_cycles", 16'(settle_exp[c]), 16'(n));
      @(negedge sys_clk);
      chk_bit("go_pulse", 1'h0, sample_go);
    end
    $display("test settle done");
    conv_off = 1'h1;
    repeat (4) @(negedge sys_clk);
    rd_chk("off", touch_ctl_pkg::ADDR_STATUS, 16'hA000);
    conv_off = 1'h0;
    self_ctl = 1'h1;
    repeat (4) @(negedge sys_clk);
    rd_chk("owner", touch_ctl_pkg::ADDR_STATUS, 16'h9000);
    self_ctl = 1'h0;
    evt(3'h1, 1'h0, 16'h1234);
    evt(3'h2, 1'h0, 16'h0567);
    evt(3'h4, 1'h1, 16'h089A);
    rd_chk("flags_set", touch_ctl_pkg::ADDR_STATUS, 16'h8F00);
    u_host.xfer(16'h8010, 16'h0000, 20, rd); // cut-short read must leave the flag
    rd_chk("flags_abort", touch_ctl_pkg::ADDR_STATUS, 16'h8F00);
    rd_chk("x_data", touch_ctl_pkg::ADDR_X, 16'h1234);
    rd_chk("x_clear", touch_ctl_pkg::ADDR_STATUS, 16'h8B00);
    rd_chk("y_data", touch_ctl_pkg::ADDR_Y, 16'h0567);
    rd_chk("y_clear", touch_ctl_pkg::ADDR_STATUS, 16'h8900);
    rd_chk("z1_data", touch_ctl_pkg::ADDR_Z1, 16'h089A);
    rd_chk("all_clear", touch_ctl_pkg::ADDR_STATUS, 16'h8000);
    $display("test flags done");
    wr(touch_ctl_pkg::ADDR_STATUS, 16'h3FFF); // only the pin field takes the write
    rd_chk("st_ro", touch_ctl_pkg::ADDR_STATUS, 16'h0000);
    pen(1'h0);
    chk_bit("pin_pen", 1'h0, pin_n);
    evt(3'h1, 1'h1, 16'h0011);
    pen(1'h1);
    chk_bit("pin_lift", 1'h1, pin_n);
    rd_chk("x_fn0", touch_ctl_pkg::ADDR_X, 16'h0011);
    $display("test pen pin done");
    wr(touch_ctl_pkg::ADDR_STATUS, 16'h4000);
    pen(1'h0);
    wr(touch_ctl_pkg::ADDR_CTL, 16'h0400);
    chk_bit("scan_on", 1'h1, cfg.scan_run);
    chk_word("scan_mode", 16'h0001, {12'h000, cfg.scan_mode});
    chk_bit("pin_rdy_idle", 1'h1, pin_n);
    evt(3'h1, 1'h0, 16'h0AAA);
    evt(3'h2, 1'h1, 16'h0BBB);
    repeat (2) @(negedge sys_clk);
    chk_bit("pin_ready", 1'h0, pin_n);
    rd_chk("x_scan", touch_ctl_pkg::ADDR_X, 16'h0AAA);
    chk_bit("pin_y_unread", 1'h0, pin_n);
    rd_chk("y_scan", touch_ctl_pkg::ADDR_Y, 16'h0BBB);
    chk_bit("pin_all_read", 1'h1, pin_n);
    wr(touch_ctl_pkg::ADDR_CTL, 16'h0000); // host stop request
    chk_bit("scan_stop", 1'h0, cfg.scan_run);
    wr(touch_ctl_pkg::ADDR_CTL, 16'h0800);
    chk_bit("scan_on2", 1'h1, cfg.scan_run);
    pen(1'h1);
    chk_bit("scan_lift", 1'h0, cfg.scan_run);
    $display("test ready pin done");
    for (int f = 2; f < 4; f++)
    begin
      wr(touch_ctl_pkg::ADDR_STATUS, {f[1:0], 14'h0000});
      pen(1'h0);
      chk_bit("pin_touch", 1'h0, pin_n);
      evt(3'h4, 1'h1, 16'h0CCC);
      repeat (2) @(negedge sys_clk);
      chk_bit("pin_done", 1'h1, pin_n);
      rd_chk("z1_fn", touch_ctl_pkg::ADDR_Z1, 16'h0CCC);
      pen(1'h1);
    end
    $display("test combined pin done");
    // clock enable low: pen sync and pin hold, converter pulses are lost
    ce = 1'h0;
    pen(1'h0);
    chk_bit("pin_frozen", 1'h1, pin_n);
    evt(3'h1, 1'h1, 16'h0DDD);
    ce = 1'h1;
    repeat (8) @(negedge sys_clk);
    chk_bit("pin_thawed", 1'h0, pin_n);
    rd_chk("st_frozen", touch_ctl_pkg::ADDR_STATUS, 16'hC000);
    pen(1'h1);
    $display("test clock enable done");
    final_report();
  end
endmodule : touch_adc_control_status_tb_top
`default_nettype wire
